// [include/sbt_pkg.sv]
// Purpose: constants and types for the serial link byte transmitter
// Assumes: CLK is the 250 MHz bit clock, one serial bit per CLK
// Notes:   code words are held in send order {a,b,c,d,e,i,f,g,h,j}, a first
package sbt_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BITS_PER_CHAR = 10;
    localparam int RP_LOW_PERCENT = 60;
    localparam int RP_LOW_CYCLES = (BITS_PER_CHAR * RP_LOW_PERCENT) / 100;
    localparam logic [3:0] BIT_CNT_LAST = 4'(BITS_PER_CHAR - 1);
    localparam logic [2:0] RP_CNT_LOAD = 3'(RP_LOW_CYCLES - 1);

    localparam logic [7:0] FILL_BYTE = 8'hBC;
    localparam logic [7:0] ALT_BYTE = 8'h4A;
    localparam logic [4:0] X_K28 = 5'h1C;
    localparam logic [4:0] X_D07 = 5'h07;
    localparam logic [2:0] Y_ALT = 3'h7;
    localparam logic [2:0] Y_D3 = 3'h3;
    localparam logic [9:0] VIOL_CODE = 10'h01F;
    localparam logic [9:0] FILL_CODE_NEG = 10'h0FA;
    localparam logic [9:0] FILL_CODE_POS = 10'h305;
    localparam logic [9:0] ALT_CODE = 10'h155;

    localparam logic [7:0] LFSR_SEED = 8'h01;
    localparam logic [7:0] LFSR_LAST = 8'h80;
    localparam logic [7:0] LFSR_TAPS = 8'hB8;

    localparam logic [1:0] ENC_SEL_LOW = 2'h0;
    localparam logic [1:0] ENC_SEL_HIGH = 2'h1;

    localparam int PIN_W = 17;
    localparam int PIN_CKW = 16;
    localparam int PIN_NOW_N = 15;
    localparam int PIN_NEXT_N = 14;
    localparam int PIN_BYTE_HI = 13;
    localparam int PIN_BYTE_LO = 6;
    localparam int PIN_SC = 5;
    localparam int PIN_VIOL = 4;
    localparam int PIN_OPT_OFF = 3;
    localparam int PIN_BIST_N = 2;
    localparam int PIN_MODE_HI = 1;
    localparam int PIN_MODE_LO = 0;

    typedef enum logic [1:0] {SBT_MODE_ENC, SBT_MODE_RAW, SBT_MODE_TEST} sbt_mode_t;
endpackage

// [core/sbt_serial_link_byte_transmitter.sv]
// Purpose: byte loader, 8b/10b encoder, self-test generator and serialiser
// Assumes: write byte clock period is ten CLK cycles; all pins asynchronous
// Notes:   a two-entry code buffer absorbs phase between byte and bit clocks
`timescale 1ns/100ps

// What this block does
// R1: load-now strobe low captures current byte
// R2: load-next strobe low captures following edge's byte
// R3: both strobes high sends K28.5 fill
// R4: character select picks special or data alphabet
// R5: force violation sends violation, ignores byte
// R6: violation overrides the self-test generator
// R7: three-level select: encode, raw, test
// R8: raw mode sends select, byte, violation bits
// R9: bit rate is ten times byte rate
// R10: optical off holds outputs A, B zero; test mode still drives them with the test clock
// R11: self-test idle sends alternating D10.2
// R12: self-test loaded sends repeating test sequence
// R13: violation during self-test restarts sequence
// R14: self-test enable sampled like data
// R15: read strobe low sixty percent per byte
// R16: self-test read strobe low once per loop
// R17: write clock paces bits and byte sampling; bits here run from CLK, the write clock only paces byte sampling
// R18: host uses one strobe for flow control
// R19: encoder tracks running disparity per character
// R20: violation code invalid in both disparities
// R21: test sequence is an agreed pseudo-random generator
module sbt_serial_link_byte_transmitter
    import sbt_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic WRITE_BYTE_CLOCK,
    input wire logic LOAD_NOW_STROBE_N,
    input wire logic LOAD_NEXT_STROBE_N,
    input wire logic [7:0] PARALLEL_BYTE_IN,
    input wire logic CONTROL_CHAR_SELECT,
    input wire logic FORCE_VIOLATION,
    input wire logic OPTICAL_OUTPUTS_OFF,
    input wire logic SELF_TEST_ENABLE_N,
    input wire logic [1:0] ENCODING_SELECT,
    output logic FIFO_READ_STROBE_N,
    output logic LOAD_READY,
    output logic SERIAL_OUT_A_P,
    output logic SERIAL_OUT_A_N,
    output logic SERIAL_OUT_B_P,
    output logic SERIAL_OUT_B_N,
    output logic SERIAL_OUT_C_P,
    output logic SERIAL_OUT_C_N
);
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CW = $clog2(BUF_DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(BUF_DEPTH);

    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
        $error("BUF_DEPTH must be a power of two, at least 2");
    end

    function automatic logic [5:0] code6(input logic [4:0] x);
        case (x)
            5'h00: code6 = 6'b100111;
            5'h01: code6 = 6'b011101;
            5'h02: code6 = 6'b101101;
            5'h03: code6 = 6'b110001;
            5'h04: code6 = 6'b110101;
            5'h05: code6 = 6'b101001;
            5'h06: code6 = 6'b011001;
            5'h07: code6 = 6'b111000;
            5'h08: code6 = 6'b111001;
            5'h09: code6 = 6'b100101;
            5'h0A: code6 = 6'b010101;
            5'h0B: code6 = 6'b110100;
            5'h0C: code6 = 6'b001101;
            5'h0D: code6 = 6'b101100;
            5'h0E: code6 = 6'b011100;
            5'h0F: code6 = 6'b010111;
            5'h10: code6 = 6'b011011;
            5'h11: code6 = 6'b100011;
            5'h12: code6 = 6'b010011;
            5'h13: code6 = 6'b110010;
            5'h14: code6 = 6'b001011;
            5'h15: code6 = 6'b101010;
            5'h16: code6 = 6'b011010;
            5'h17: code6 = 6'b111010;
            5'h18: code6 = 6'b110011;
            5'h19: code6 = 6'b100110;
            5'h1A: code6 = 6'b010110;
            5'h1B: code6 = 6'b110110;
            5'h1C: code6 = 6'b001110;
            5'h1D: code6 = 6'b101110;
            5'h1E: code6 = 6'b011110;
            default: code6 = 6'b101011;
        endcase
    endfunction

    // negative-disparity forms; k selects the special-character column
    function automatic logic [3:0] code4(input logic [2:0] y, input logic k);
        case (y)
            3'h0: code4 = 4'b1011;
            3'h1: code4 = k ? 4'b0110 : 4'b1001;
            3'h2: code4 = k ? 4'b1010 : 4'b0101;
            3'h3: code4 = 4'b1100;
            3'h4: code4 = 4'b1101;
            3'h5: code4 = k ? 4'b0101 : 4'b1010;
            3'h6: code4 = k ? 4'b1001 : 4'b0110;
            default: code4 = k ? 4'b0111 : 4'b1110;
        endcase
    endfunction

    // returns {running disparity after, code}; rd high means positive
    function automatic logic [10:0] enc_char(input logic [7:0] b, input logic k,
                                             input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic rd6;
        logic alt;
        logic [4:0] x;
        logic [2:0] y;
        x = b[4:0];
        y = b[7:5];
        c6 = (k && x == X_K28) ? 6'b001111 : code6(x); // R4
        if (rd && ($countones(c6) != 3 || x == X_D07)) begin
            c6 = ~c6; // R19
        end
        rd6 = ($countones(c6) == 3) ? rd : ~rd;
        alt = !k && y == Y_ALT && ((!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
              || (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        c4 = alt ? 4'b0111 : code4(y, k);
        if (rd6 && (k || $countones(c4) != 2 || y == Y_D3)) begin
            c4 = ~c4; // R19
        end
        enc_char = {(($countones(c4) == 2) ? rd6 : ~rd6), c6, c4};
    endfunction

    // pin synchronisers: s1 feeds only s2; d3 is one sample older than s2
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_d3;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_d3 <= '0;
        end else if (CE) begin
            pin_s1 <= {WRITE_BYTE_CLOCK, LOAD_NOW_STROBE_N, LOAD_NEXT_STROBE_N,
                       PARALLEL_BYTE_IN, CONTROL_CHAR_SELECT, FORCE_VIOLATION,
                       OPTICAL_OUTPUTS_OFF, SELF_TEST_ENABLE_N, ENCODING_SELECT};
            pin_s2 <= pin_s1;
            pin_d3 <= pin_s2;
        end
    end

    // data is taken from the sample just before the clock rose: setup value
    logic byte_edge;
    logic now_n;
    logic next_n;
    logic [7:0] byte_in;
    logic sc;
    logic viol;
    logic bist_n;
    logic opt_off;
    sbt_mode_t mode;
    assign byte_edge = pin_s2[PIN_CKW] && !pin_d3[PIN_CKW]; // R17
    assign now_n = pin_d3[PIN_NOW_N];
    assign next_n = pin_d3[PIN_NEXT_N];
    assign byte_in = pin_d3[PIN_BYTE_HI:PIN_BYTE_LO];
    assign sc = pin_d3[PIN_SC];
    assign viol = pin_d3[PIN_VIOL];
    assign bist_n = pin_d3[PIN_BIST_N]; // R14
    assign opt_off = pin_s2[PIN_OPT_OFF];

    always_comb begin
        if (pin_s2[PIN_MODE_HI:PIN_MODE_LO] == ENC_SEL_LOW) begin
            mode = SBT_MODE_ENC; // R7
        end else if (pin_s2[PIN_MODE_HI:PIN_MODE_LO] == ENC_SEL_HIGH) begin
            mode = SBT_MODE_RAW;
        end else begin
            mode = SBT_MODE_TEST;
        end
    end

    logic pend_next;
    logic rd;
    logic [7:0] lfsr;
    logic load;
    logic [10:0] enc_out;
    logic [9:0] next_word;
    logic next_rd;
    logic enq_valid;
    logic enq_ready;
    assign load = !now_n || pend_next; // R1 R2

    always_comb begin
        next_rd = rd;
        enc_out = enc_char(FILL_BYTE, 1'b1, rd); // R3
        if (!bist_n) begin
            enc_out = load ? enc_char(lfsr, 1'b0, rd) : enc_char(ALT_BYTE, 1'b0, rd); // R11 R12
        end else if (load) begin
            enc_out = enc_char(byte_in, sc, rd); // R1 R4
        end
        case (mode)
            SBT_MODE_RAW: begin
                next_word = load ? {sc, {<<{byte_in}}, viol} : enc_out[9:0]; // R8
                if (!load) begin
                    next_rd = enc_out[10];
                end
            end
            default: begin
                if (viol) begin
                    next_word = VIOL_CODE; // R5 R6 R20
                end else begin
                    next_word = enc_out[9:0];
                    next_rd = enc_out[10];
                end
            end
        endcase
    end

    assign enq_valid = byte_edge && mode != SBT_MODE_TEST;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pend_next <= 1'b0;
        end else if (CE && byte_edge) begin
            pend_next <= !next_n; // R2
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd <= 1'b0;
        end else if (CE && enq_valid && enq_ready) begin
            rd <= next_rd; // R19
        end
    end

    // free running while loaded; reset, and a violation while self-test is enabled, both reload the seed
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            lfsr <= LFSR_SEED;
        end else if (CE && byte_edge && !bist_n) begin
            if (viol) begin
                lfsr <= LFSR_SEED; // R13
            end else if (load) begin
                lfsr <= {lfsr[6:0], ^(lfsr & LFSR_TAPS)}; // R12 R21
            end
        end
    end

    // read strobe: six CLK low per byte, independent of write clock duty
    logic [2:0] rp_cnt;
    logic rp_start;
    assign rp_start = byte_edge && (bist_n ? !now_n : (load && lfsr == LFSR_LAST));
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rp_cnt <= '0;
            FIFO_READ_STROBE_N <= 1'b1;
        end else if (CE) begin
            if (rp_start) begin
                rp_cnt <= RP_CNT_LOAD; // R15 R16
                FIFO_READ_STROBE_N <= 1'b0;
            end else if (rp_cnt != '0) begin
                rp_cnt <= rp_cnt - 3'h1;
            end else begin
                FIFO_READ_STROBE_N <= 1'b1;
            end
        end
    end

    // two-entry code buffer between byte loader and serialiser
    logic [9:0] buf_mem [BUF_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] buf_cnt;
    logic [3:0] bit_cnt;
    logic deq_ready;
    logic deq_valid;
    logic do_enq;
    logic do_deq;
    assign enq_ready = buf_cnt != CNT_FULL;
    assign deq_valid = buf_cnt != '0;
    assign deq_ready = bit_cnt == BIT_CNT_LAST && mode != SBT_MODE_TEST;
    assign do_enq = enq_valid && enq_ready;
    assign do_deq = deq_valid && deq_ready;

    always_ff @(posedge CLK) begin
        if (CE && do_enq) begin
            buf_mem[wr_ptr] <= next_word;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            buf_cnt <= '0;
            LOAD_READY <= 1'b1;
        end else if (CE) begin
            if (do_enq) begin
                wr_ptr <= wr_ptr + PW'(1);
            end
            if (do_deq) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
            if (do_enq && !do_deq) begin
                buf_cnt <= buf_cnt + CW'(1);
                LOAD_READY <= (buf_cnt + CW'(1)) != CNT_FULL;
            end else if (do_deq && !do_enq) begin
                buf_cnt <= buf_cnt - CW'(1);
                LOAD_READY <= 1'b1;
            end
        end
    end

    // serialiser: one bit per CLK; mid-level select stops the bit clock
    logic [9:0] shreg;
    logic test_clk;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bit_cnt <= '0;
            shreg <= FILL_CODE_NEG;
            test_clk <= 1'b0;
        end else if (CE) begin
            if (mode == SBT_MODE_TEST) begin
                test_clk <= !test_clk; // R7
            end else if (bit_cnt == BIT_CNT_LAST) begin
                bit_cnt <= '0; // R9
                // an underrun repeats fill; disparity may slip once there
                shreg <= deq_valid ? buf_mem[rd_ptr] : FILL_CODE_NEG;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shreg <= {shreg[8:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SERIAL_OUT_A_P <= 1'b0;
            SERIAL_OUT_A_N <= 1'b1;
            SERIAL_OUT_B_P <= 1'b0;
            SERIAL_OUT_B_N <= 1'b1;
            SERIAL_OUT_C_P <= 1'b0;
            SERIAL_OUT_C_N <= 1'b1;
        end else if (CE) begin
            if (mode == SBT_MODE_TEST) begin
                SERIAL_OUT_A_P <= test_clk; // R7
                SERIAL_OUT_A_N <= test_clk;
                SERIAL_OUT_B_P <= !test_clk;
                SERIAL_OUT_B_N <= !test_clk;
            end else begin
                SERIAL_OUT_A_P <= shreg[9] && !opt_off; // R10
                SERIAL_OUT_A_N <= !(shreg[9] && !opt_off);
                SERIAL_OUT_B_P <= shreg[9] && !opt_off;
                SERIAL_OUT_B_N <= !(shreg[9] && !opt_off);
            end
            SERIAL_OUT_C_P <= shreg[9];
            SERIAL_OUT_C_N <= !shreg[9];
        end
    end

    a_load_now_data: assert property (@(posedge CLK) disable iff (!RST_B) // R1
        byte_edge && !now_n && bist_n && !viol && mode == SBT_MODE_ENC
        |-> next_word == enc_char(byte_in, sc, rd)[9:0])
        else $error("load-now byte not encoded");
    a_load_next_taken: assert property (@(posedge CLK) disable iff (!RST_B || !CE) // R2
        byte_edge && !next_n ##1 (!byte_edge)[*5] ##[1:5] byte_edge |-> load)
        else $error("load-next byte not taken at following edge");
    a_fill_when_idle: assert property (@(posedge CLK) disable iff (!RST_B) // R3
        byte_edge && !load && bist_n && !viol && mode == SBT_MODE_ENC
        |-> next_word == FILL_CODE_NEG || next_word == FILL_CODE_POS)
        else $error("idle byte is not fill");
    a_viol_over_bist: assert property (@(posedge CLK) disable iff (!RST_B) // R5 R6
        byte_edge && viol && mode == SBT_MODE_ENC |-> next_word == VIOL_CODE
        && next_rd == rd)
        else $error("violation not sent");
    a_raw_passthru: assert property (@(posedge CLK) disable iff (!RST_B) // R8
        byte_edge && load && mode == SBT_MODE_RAW
        |-> next_word == {sc, byte_in[0], byte_in[1], byte_in[2], byte_in[3],
                          byte_in[4], byte_in[5], byte_in[6], byte_in[7], viol})
        else $error("raw word misordered");
    a_bit_period: assert property (@(posedge CLK) disable iff (!RST_B || !CE) // R9
        bit_cnt == '0 && mode != SBT_MODE_TEST ##1 (mode != SBT_MODE_TEST)[*8]
        ##1 mode != SBT_MODE_TEST
        |-> bit_cnt == BIT_CNT_LAST)
        else $error("word is not ten bits long");
    a_optical_off: assert property (@(posedge CLK) disable iff (!RST_B || !CE) // R10
        opt_off && mode != SBT_MODE_TEST
        |=> !SERIAL_OUT_A_P && SERIAL_OUT_A_N && !SERIAL_OUT_B_P && SERIAL_OUT_B_N
            && SERIAL_OUT_C_P == $past(shreg[9]))
        else $error("optical off not honoured");
    a_bist_alternate: assert property (@(posedge CLK) disable iff (!RST_B) // R11
        byte_edge && !bist_n && !load && !viol && mode == SBT_MODE_ENC
        |-> next_word == ALT_CODE)
        else $error("self-test idle not alternating");
    a_bist_restart: assert property (@(posedge CLK) disable iff (!RST_B || !CE) // R13
        byte_edge && !bist_n && viol |=> lfsr == LFSR_SEED)
        else $error("self-test sequence not restarted");
    a_read_strobe_low: assert property (@(posedge CLK) disable iff (!RST_B || !CE) // R15
        $fell(FIFO_READ_STROBE_N) |-> !FIFO_READ_STROBE_N[*6] ##1 FIFO_READ_STROBE_N)
        else $error("read strobe width wrong");
    a_bist_strobe: assert property (@(posedge CLK) disable iff (!RST_B || !CE) // R16
        byte_edge && !bist_n && lfsr != LFSR_LAST |=> FIFO_READ_STROBE_N)
        else $error("read strobe pulsed inside self-test loop");
    a_disparity_span: assert property (@(posedge CLK) disable iff (!RST_B) // R19
        byte_edge && mode == SBT_MODE_ENC && !viol
        |-> $countones(next_word) >= 4 && $countones(next_word) <= 6
            && (($countones(next_word) == 5) == (next_rd == rd)))
        else $error("code word disparity out of range");
endmodule // sbt_serial_link_byte_transmitter

// [bench/sbt_host_model.sv]
// Purpose: host model that feeds parallel bytes and the free running write byte clock
// Assumes: byte period is ten CLK, every pin changes on a CLK falling edge
// Notes:   data changes mid-period so it is settled long before each byte edge
`timescale 1ns/100ps
module sbt_host_model (
    input wire logic CLK,
    input wire logic [1:0] load_kind,
    input wire logic k_on,
    input wire logic viol_on,
    input wire logic raw_on,
    input wire logic bist_on,
    input wire logic [7:0] rnd,
    output logic byte_clk = 1'b0,
    output logic now_n = 1'b1,
    output logic next_n = 1'b1,
    output logic [7:0] data = 8'h00,
    output logic sc = 1'b0,
    output logic viol = 1'b0,
    output logic bist_n = 1'b1,
    output logic slot = 1'b0
);
    int cnt = 0;
    logic k_pick;

    assign k_pick = k_on && !raw_on && rnd[1:0] == 2'h0;

    always @(negedge CLK) begin
        cnt <= (cnt == 9) ? 0 : cnt + 1;
        slot <= (cnt == 4);
        // crystal-like time base: it never stops, not even during reset
        if (cnt == 9)
            byte_clk <= 1'b1;
        if (cnt == 4) begin
            byte_clk <= 1'b0;
            bist_n <= !bist_on;
            // one strobe carries flow control, the other stays parked high
            now_n <= !(load_kind == 2'h1 || (load_kind == 2'h3 && rnd[2]));
            next_n <= !(load_kind == 2'h2 && rnd[3]);
            sc <= k_pick;
            // only K28.y is offered: other specials are defined only with y of 7
            data <= k_pick ? {rnd[7:5], 5'h1C} : rnd;
            // raw words keep a low and j high so they never look like fill
            viol <= raw_on || (viol_on && rnd[7:6] == 2'h0);
        end
    end
endmodule // sbt_host_model

// [bench/tb.sv]
// Purpose: self-checking bench for the serial link byte transmitter
// Assumes: host model paces bytes at exactly ten CLK, word alignment from the reset fill
// Notes:   pad fills from an empty buffer are skipped, so fill counts are not exact
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch t=%0t %s", $time, m); end end
module tb
    import sbt_pkg::*;
;
    localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32,
        6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic opt_off = 1'b0;
    logic [1:0] enc_sel = ENC_SEL_LOW;
    logic [1:0] load_kind = 2'h0;
    logic k_on = 1'b0, viol_on = 1'b0, raw_on = 1'b0, bist_on = 1'b0;
    logic [7:0] rnd = 8'h00;
    logic wbc, now_n, next_n, sc, viol, bist_n, slot;
    logic [7:0] data;
    logic rd_strobe_n, load_ready, a_p, a_n, b_p, b_n, c_p, c_n;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    int exp_pulses = 0, got_pulses = 0, low_len = 0, bc = 0;
    logic [9:0] exp_q[$];
    logic rd = 1'b0, pend = 1'b0, aligned = 1'b0;
    logic [7:0] lfsr = LFSR_SEED, opt_h = 8'h00;
    logic [9:0] w = 10'h000;

    always #2 CLK = ~CLK;

    sbt_host_model u_sbt_host_model (.CLK(CLK), .load_kind(load_kind), .k_on(k_on),
        .viol_on(viol_on), .raw_on(raw_on), .bist_on(bist_on), .rnd(rnd), .byte_clk(wbc),
        .now_n(now_n), .next_n(next_n), .data(data), .sc(sc), .viol(viol), .bist_n(bist_n),
        .slot(slot));

    sbt_serial_link_byte_transmitter u_sbt_serial_link_byte_transmitter (.CLK(CLK),
        .RST_B(RST_B), .CE(1'b1), .WRITE_BYTE_CLOCK(wbc), .LOAD_NOW_STROBE_N(now_n),
        .LOAD_NEXT_STROBE_N(next_n), .PARALLEL_BYTE_IN(data), .CONTROL_CHAR_SELECT(sc),
        .FORCE_VIOLATION(viol), .OPTICAL_OUTPUTS_OFF(opt_off), .SELF_TEST_ENABLE_N(bist_n),
        .ENCODING_SELECT(enc_sel), .FIFO_READ_STROBE_N(rd_strobe_n), .LOAD_READY(load_ready),
        .SERIAL_OUT_A_P(a_p), .SERIAL_OUT_A_N(a_n), .SERIAL_OUT_B_P(b_p),
        .SERIAL_OUT_B_N(b_n), .SERIAL_OUT_C_P(c_p), .SERIAL_OUT_C_N(c_n));

    function automatic logic [9:0] enc(input logic [7:0] b, input logic k, input logic r0);
        logic [5:0] s;
        logic [3:0] f;
        logic r;
        s = T6[b[4:0]];
        if (k && b[4:0] == 5'h1C) begin
            f = (b[7:5] == 3'h7) ? 4'h8 : T4[b[7:5]];
            if (b[7:5] == 3'h0 || b[7:5] == 3'h3 || b[7:5] == 3'h4)
                f = ~f;
            return r0 ? ~{6'h0F, f} : {6'h0F, f};
        end
        if (r0 && ($countones(s) != 3 || b[4:0] == 5'h07))
            s = ~s;
        r = r0 ^ ($countones(s) != 3);
        f = T4[b[7:5]];
        if (b[7:5] == 3'h7 && (k || (!r && b[4:0] inside {5'h11, 5'h12, 5'h14})
                || (r && b[4:0] inside {5'h0B, 5'h0D, 5'h0E})))
            f = 4'h7;
        if (r && ($countones(f) != 2 || b[7:5] == 3'h3))
            f = ~f;
        return {s, f};
    endfunction

    // reference device: one expected word per byte edge, strobe pulses counted
    always @(posedge wbc) begin
        logic ld;
        logic [9:0] code;
        if (RST_B && !enc_sel[1]) begin
            ld = !now_n || pend;
            pend = !next_n;
            `CHK(load_ready, 1'b1, "byte edge refused")
            if (enc_sel == ENC_SEL_HIGH && ld)
                code = {sc, data[0], data[1], data[2], data[3], data[4], data[5], data[6],
                    data[7], viol};
            else if (viol && enc_sel == ENC_SEL_LOW) begin
                code = VIOL_CODE;
                if (!bist_n)
                    lfsr = LFSR_SEED;
            end else if (!bist_n && enc_sel == ENC_SEL_LOW) begin
                code = enc(ld ? lfsr : ALT_BYTE, 1'b0, rd);
                if (ld && lfsr == LFSR_LAST)
                    exp_pulses++;
                if (ld)
                    lfsr = {lfsr[6:0], ^(lfsr & LFSR_TAPS)};
            end else
                code = ld ? enc(data, sc, rd) : enc(FILL_BYTE, 1'b1, rd);
            if (bist_n && !now_n)
                exp_pulses++;
            if (!(enc_sel == ENC_SEL_HIGH && ld))
                rd = rd ^ ($countones(code) != 5);
            exp_q.push_back(code);
        end
    end

    task automatic check_word(input logic [9:0] got);
        logic is_fill;
        is_fill = got == FILL_CODE_NEG || got == FILL_CODE_POS;
        if (exp_q.size() > 0 && (got === exp_q[0] || !is_fill)) begin
            `CHK(got, exp_q[0], "serial word")
            void'(exp_q.pop_front());
        end else if (!is_fill)
            `CHK(got, 10'h3FF, "word with nothing queued")
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // serial receiver, pin pairs and strobe width, all sampled where outputs are settled
    always @(negedge CLK) begin
        cycles++;
        if (cycles == 12000) begin
            n_mismatch++;
            complete_run();
        end
        opt_h = {opt_h[6:0], opt_off};
        if (RST_B && !enc_sel[1]) begin
            `CHK(c_n, ~c_p, "c pair")
            if (opt_h == 8'hFF)
                `CHK({a_p, a_n, b_p, b_n}, 4'h5, "optical off")
            else if (opt_h == 8'h00)
                `CHK({a_p, a_n, b_p, b_n}, {c_p, c_n, c_p, c_n}, "a b follow c")
            w = {w[8:0], c_p};
            bc = (bc == 9) ? 0 : bc + 1;
            if (!aligned && w == FILL_CODE_NEG) begin
                aligned = 1'b1;
                bc = 0;
            end else if (aligned && bc == 0)
                check_word(w);
        end
        if (rd_strobe_n === 1'b0)
            low_len++;
        else if (low_len > 0) begin
            got_pulses++;
            `CHK(low_len, RP_LOW_CYCLES, "read strobe width")
            low_len = 0;
        end
    end

    task automatic run(input string name, input logic [1:0] lk, input logic k, input logic v,
            input logic rw, input logic bi, input int n);
        @(posedge slot);
        load_kind = lk;
        k_on = k;
        viol_on = v;
        raw_on = rw;
        bist_on = bi;
        enc_sel = rw ? ENC_SEL_HIGH : ENC_SEL_LOW;
        repeat (n) @(posedge slot);
        load_kind = 2'h0;
        viol_on = 1'b0;
        raw_on = 1'b0;
        bist_on = 1'b0;
        repeat (5) @(posedge slot);
        `CHK(got_pulses, exp_pulses, "read strobe count")
        $display("test %s done", name);
    endtask

    initial begin
        void'($urandom(57138));
        fork
            forever @(negedge CLK) rnd = 8'($urandom);
        join_none
        repeat (8) @(negedge CLK);
        @(posedge slot);
        RST_B = 1'b1;
        run("load_now", 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 40);
        opt_off = 1'b1;
        run("load_next_special", 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 40);
        opt_off = 1'b0;
        run("pulsed_violation", 2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 40);
        run("raw_words", 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 30);
        run("self_test_idle", 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 6);
        run("self_test_restart", 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 12);
        run("self_test_loop", 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 260);
        // test mode stops the shifter, so only the clock pins are checked
        enc_sel = 2'h2;
        repeat (12) @(negedge CLK);
        repeat (20) begin
            @(negedge CLK);
            `CHK({a_n, b_p, b_n}, {a_p, ~a_p, ~a_p}, "test clock pins")
        end
        $display("test test_mode done");
        complete_run();
    end
endmodule // tb
